// file: ssa_pkg.sv
/*
  Constants, register map and types shared by the shift/subtract/stop datapath.
  Assumes an 8-bit register file of 256 bytes and a 32-bit AXI4-Lite bus in front.
*/
// Contract
// - An arithmetic right shift moves every bit one place down, keeps bit 7 and copies it into bit 6.
// - After the shift, carry is the old bit 0, zero and sign follow the result, overflow is 0, D and H hold.
// - A register byte whose upper nibble is 1110b names the working register given by its low nibble.
// - Opcode 6F is one byte long, takes 6 cycles, stops core and crystal clocks and leaves the flags.
// - Only a reset leaves the halted state, and afterwards fetching restarts at address 000Ch.
// - Subtract adds the two's complement of the source to the destination, writes the destination only.
// - Subtract opcodes 22 and 23 take 6 cycles, opcodes 24 to 27 take 10 cycles.
// - Full register forms carry the source byte first, immediate forms carry the destination first.
// - For both subtracts carry is cleared on a carry out of bit 7 and set otherwise, marking a borrow.
// - For both subtracts half-carry is cleared on a carry out of the low nibble and set otherwise.
// - Overflow is set when the operands differ in sign and the result sign equals the source sign.
// - Zero marks a zero result, sign a negative one, and the decimal-adjust flag always becomes 1.
// - Subtract with borrow takes destination minus source minus carry into the destination.
// - Subtract-with-borrow opcodes 32 to 37 share modes, byte order and cycle counts with 22 to 27.
package ssa_pkg;

  typedef enum logic [1:0] {ALU_SHIFT, ALU_SUB, ALU_SBC} alu_op_t;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_INSTR   = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_FLAGS   = 8'h0c;
  localparam logic [7:0] OFF_POINTER = 8'h10;
  localparam logic [7:0] OFF_PC      = 8'h14;
  localparam logic [7:0] OFF_REGADDR = 8'h18;
  localparam logic [7:0] OFF_REGDATA = 8'h1c;

  localparam int CTRL_START     = 0;
  localparam int CTRL_CLR_ILL   = 1;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_HALTED    = 1;
  localparam int STAT_ILLEGAL   = 2;

  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAG_MASK  = 8'hfc;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  localparam logic [7:0] OP_SHIFT_R  = 8'hd0;
  localparam logic [7:0] OP_SHIFT_IR = 8'hd1;
  localparam logic [7:0] OP_STOP     = 8'h6f;
  localparam logic [3:0] GRP_SUB     = 4'h2;
  localparam logic [3:0] GRP_SBC     = 4'h3;
  localparam logic [3:0] MODE_PAIR     = 4'h2;
  localparam logic [3:0] MODE_PAIR_IND = 4'h3;
  localparam logic [3:0] MODE_FULL     = 4'h4;
  localparam logic [3:0] MODE_FULL_IND = 4'h5;
  localparam logic [3:0] MODE_IMM      = 4'h6;
  localparam logic [3:0] MODE_IND_IMM  = 4'h7;
  localparam logic [3:0] WORK_NIBBLE   = 4'he;

  localparam logic [3:0]  CYC_SHORT  = 4'h6;
  localparam logic [3:0]  CYC_LONG   = 4'ha;
  localparam logic [15:0] LEN_ONE    = 16'h0001;
  localparam logic [15:0] LEN_TWO    = 16'h0002;
  localparam logic [15:0] LEN_THREE  = 16'h0003;
  localparam logic [15:0] RESTART_PC = 16'h000c;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: datapath_ifs.sv
/*
  Interfaces between the controller and its register store and arithmetic unit.
  Assumes both ends run on the same clock; these carry no timing of their own.
*/
`timescale 1ns/10ps
`default_nettype none

interface store_port_if;
  logic [7:0] raddrA;
  logic [7:0] raddrB;
  logic [7:0] rdataA;
  logic [7:0] rdataB;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  modport user  (output raddrA, raddrB, we, waddr, wdata, input rdataA, rdataB);
  modport store (input raddrA, raddrB, we, waddr, wdata, output rdataA, rdataB);
endinterface

interface alu_port_if;
  ssa_pkg::alu_op_t kind;
  logic [7:0]       dst;
  logic [7:0]       src;
  logic [7:0]       flagsIn;
  logic [7:0]       result;
  logic [7:0]       flagsOut;
  modport user (output kind, dst, src, flagsIn, input result, flagsOut);
  modport unit (input kind, dst, src, flagsIn, output result, flagsOut);
endinterface

`default_nettype wire

// file: operand_store.sv
/*
  The 256-byte register file: two combinational read ports, one write port.
  Assumes the controller never asks for two writes in one cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module operand_store (
  input wire logic   mclk,
  store_port_if.store port
);
  // Contents carry no reset; software loads what it needs
  logic [7:0] mem [256];

  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  assign port.rdataA = mem[port.raddrA];
  assign port.rdataB = mem[port.raddrB];

endmodule // operand_store

`default_nettype wire

// file: flag_alu.sv
/*
  Combinational result and flag logic for the right shift and both subtracts.
  Assumes flagsIn is the current flag byte; untouched flags pass through.
*/
`timescale 1ns/10ps
`default_nettype none

module flag_alu (
  alu_port_if.unit alu
);
  logic [8:0] wide;
  logic [4:0] low;
  logic       cin;
  logic [7:0] res;
  logic [7:0] fl;

  always_comb begin
    wide = 9'h000;
    low  = 5'h00;
    cin  = 1'b1;
    fl   = alu.flagsIn;
    res  = alu.dst;
    unique case (alu.kind)
      ssa_pkg::ALU_SHIFT: begin
        res = {alu.dst[7], alu.dst[7:1]};
        fl[ssa_pkg::FLAG_C] = alu.dst[0];
        fl[ssa_pkg::FLAG_V] = 1'b0;
      end
      ssa_pkg::ALU_SUB, ssa_pkg::ALU_SBC: begin
        // Borrow in is the inverted carry added as the two's complement's +1
        if (alu.kind == ssa_pkg::ALU_SBC) begin
          cin = ~alu.flagsIn[ssa_pkg::FLAG_C];
        end
        wide = {1'b0, alu.dst} + {1'b0, ~alu.src} + {8'h00, cin};
        low  = {1'b0, alu.dst[3:0]} + {1'b0, ~alu.src[3:0]} + {4'h0, cin};
        res  = wide[7:0];
        fl[ssa_pkg::FLAG_C] = ~wide[8];
        fl[ssa_pkg::FLAG_H] = ~low[4];
        fl[ssa_pkg::FLAG_V] = (alu.dst[7] != alu.src[7]) && (res[7] == alu.src[7]);
        fl[ssa_pkg::FLAG_D] = 1'b1;
      end
    endcase
    fl[ssa_pkg::FLAG_Z] = (res == 8'h00);
    fl[ssa_pkg::FLAG_S] = res[7];
  end

  assign alu.result   = res;
  assign alu.flagsOut = fl & ssa_pkg::FLAG_MASK;

endmodule // flag_alu

`default_nettype wire

// file: shift_subtract_stop_alu.sv
/*
  Executes one shift, subtract, subtract-with-borrow or stop instruction loaded over
  AXI4-Lite, against the internal register file, and keeps the flags and fetch address.
  Assumes software loads the instruction bytes, then writes the start bit.
*/
`timescale 1ns/10ps
`default_nettype none

module shift_subtract_stop_alu (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             sclkEnable,
  output logic             xtalEnable
);
  typedef enum logic [2:0] {IDLE, RESOLVE, EXECUTE, SETTLE, HALTED} core_state_t;

  core_state_t state;
  logic [3:0]  cnt;
  logic [23:0] instr;
  logic [7:0]  pointer;
  logic [7:0]  regAddr;
  logic [7:0]  flags;
  logic [15:0] pc;
  logic        illegal;
  logic        startPulse;
  logic [7:0]  dstEff;
  logic [7:0]  srcEff;
  logic [7:0]  awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0]  wStrbHeld;
  logic        awHave;
  logic        wHave;
  logic        doWrite;
  logic        writeOk;
  logic        editable;
  logic        busy;
  logic [31:0] readWord;
  logic [1:0]  readResp;

  logic [7:0]       b1;
  logic [7:0]       b2;
  logic [7:0]       dstRaw;
  logic [7:0]       srcRaw;
  logic             dstInd;
  logic             srcInd;
  logic             useImm;
  logic             legal;
  logic             isStop;
  logic [3:0]       cycles;
  logic [15:0]      len;
  ssa_pkg::alu_op_t aluOp;

  store_port_if rfBus();
  alu_port_if   aluBus();

  operand_store u_store (
    .mclk (mclk),
    .port (rfBus)
  );

  flag_alu u_alu (
    .alu (aluBus)
  );

  assign busy     = (state == RESOLVE) || (state == EXECUTE) || (state == SETTLE);
  assign editable = (state == IDLE) || (state == HALTED);
  assign doWrite  = awHave && wHave && !bvalid;

  function automatic logic [7:0] workReg(input logic [7:0] raw, input logic [7:0] rp);
    if (raw[7:4] == ssa_pkg::WORK_NIBBLE) begin
      return {rp[7:4], raw[3:0]};
    end
    return raw;
  endfunction

  // Decode; instruction bytes and pointer are frozen while busy
  always_comb begin
    b1     = instr[15:8];
    b2     = instr[23:16];
    dstRaw = b1;
    srcRaw = b2;
    dstInd = 1'b0;
    srcInd = 1'b0;
    useImm = 1'b0;
    legal  = 1'b0;
    isStop = 1'b0;
    aluOp  = ssa_pkg::ALU_SUB;
    cycles = ssa_pkg::CYC_LONG;
    len    = ssa_pkg::LEN_THREE;
    if (instr[7:0] == ssa_pkg::OP_STOP) begin
      isStop = 1'b1;
      legal  = 1'b1;
      cycles = ssa_pkg::CYC_SHORT;
      len    = ssa_pkg::LEN_ONE;
    end else if (instr[7:0] == ssa_pkg::OP_SHIFT_R || instr[7:0] == ssa_pkg::OP_SHIFT_IR) begin
      legal  = 1'b1;
      aluOp  = ssa_pkg::ALU_SHIFT;
      dstRaw = workReg(b1, pointer);
      srcRaw = dstRaw;
      dstInd = instr[0];
      cycles = ssa_pkg::CYC_SHORT;
      len    = ssa_pkg::LEN_TWO;
    end else if (instr[7:4] == ssa_pkg::GRP_SUB || instr[7:4] == ssa_pkg::GRP_SBC) begin
      legal = 1'b1;
      if (instr[7:4] == ssa_pkg::GRP_SBC) begin
        aluOp = ssa_pkg::ALU_SBC;
      end
      unique case (instr[3:0])
        ssa_pkg::MODE_PAIR, ssa_pkg::MODE_PAIR_IND: begin
          dstRaw = {pointer[7:4], b1[7:4]};
          srcRaw = {pointer[7:4], b1[3:0]};
          srcInd = instr[0];
          cycles = ssa_pkg::CYC_SHORT;
          len    = ssa_pkg::LEN_TWO;
        end
        ssa_pkg::MODE_FULL, ssa_pkg::MODE_FULL_IND: begin
          srcRaw = workReg(b1, pointer);
          dstRaw = workReg(b2, pointer);
          srcInd = instr[0];
        end
        ssa_pkg::MODE_IMM, ssa_pkg::MODE_IND_IMM: begin
          dstRaw = workReg(b1, pointer);
          dstInd = instr[0];
          useImm = 1'b1;
        end
        default: legal = 1'b0;
      endcase
    end
  end

  always_comb begin
    rfBus.raddrA = regAddr;
    rfBus.raddrB = srcRaw;
    if (state == RESOLVE) begin
      rfBus.raddrA = dstRaw;
    end else if (state == EXECUTE) begin
      rfBus.raddrA = dstEff;
      rfBus.raddrB = srcEff;
    end
  end

  always_comb begin
    rfBus.we    = doWrite && writeOk && awAddrHeld == ssa_pkg::OFF_REGDATA && wStrbHeld[0];
    rfBus.waddr = regAddr;
    rfBus.wdata = wDataHeld[7:0];
    if (state == EXECUTE && !isStop) begin
      rfBus.we    = 1'b1;
      rfBus.waddr = dstEff;
      rfBus.wdata = aluBus.result;
    end
  end

  assign aluBus.kind    = aluOp;
  assign aluBus.dst     = rfBus.rdataA;
  assign aluBus.src     = useImm ? b2 : rfBus.rdataB;
  assign aluBus.flagsIn = flags;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state  <= IDLE;
      cnt    <= 4'h0;
      dstEff <= 8'h00;
      srcEff <= 8'h00;
    end else begin
      unique case (state)
        IDLE: begin
          if (startPulse && legal) begin
            state <= RESOLVE;
            cnt   <= 4'h1;
          end
        end
        RESOLVE: begin
          dstEff <= dstInd ? rfBus.rdataA : dstRaw;
          srcEff <= srcInd ? rfBus.rdataB : srcRaw;
          state  <= EXECUTE;
          cnt    <= cnt + 4'h1;
        end
        EXECUTE: begin
          state <= SETTLE;
          cnt   <= cnt + 4'h1;
        end
        SETTLE: begin
          if (cnt == cycles) begin
            state <= isStop ? HALTED : IDLE;
          end else begin
            cnt <= cnt + 4'h1;
          end
        end
        HALTED: state <= HALTED;
      endcase
    end
  end

  // Stopping drops the core and crystal clock enables on the edge that enters HALTED, where execution freezes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sclkEnable <= 1'b1;
      xtalEnable <= 1'b1;
    end else if (state == SETTLE && cnt == cycles && isStop) begin
      sclkEnable <= 1'b0;
      xtalEnable <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pc <= ssa_pkg::RESTART_PC;
    end else if (state == SETTLE && cnt == cycles && !isStop) begin
      pc <= pc + len;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flags <= ssa_pkg::FLAG_RESET;
    end else if (state == EXECUTE && !isStop) begin
      flags <= aluBus.flagsOut;
    end else if (doWrite && writeOk && awAddrHeld == ssa_pkg::OFF_FLAGS && wStrbHeld[0]) begin
      flags <= wDataHeld[7:0] & ssa_pkg::FLAG_MASK;
    end
  end

  always_comb begin
    unique case (awAddrHeld)
      ssa_pkg::OFF_CTRL: writeOk = 1'b1;
      ssa_pkg::OFF_INSTR, ssa_pkg::OFF_FLAGS, ssa_pkg::OFF_POINTER,
      ssa_pkg::OFF_REGADDR, ssa_pkg::OFF_REGDATA: writeOk = editable;
      default: writeOk = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHave     <= 1'b0;
      wHave      <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= ssa_pkg::RESP_OKAY;
      awAddrHeld <= 8'h00;
      wDataHeld  <= 32'h0000_0000;
      wStrbHeld  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awAddrHeld <= awaddr;
        awHave     <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wDataHeld <= wdata;
        wStrbHeld <= wstrb;
        wHave     <= 1'b1;
        wready    <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= writeOk ? ssa_pkg::RESP_OKAY : ssa_pkg::RESP_SLVERR;
        awHave <= 1'b0;
        wHave  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  generate
    for (genvar lane = 0; lane < 3; lane++) begin : g_instr_lane
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          instr[lane*8 +: 8] <= 8'h00;
        end else if (doWrite && writeOk && awAddrHeld == ssa_pkg::OFF_INSTR && wStrbHeld[lane]) begin
          instr[lane*8 +: 8] <= wDataHeld[lane*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pointer <= 8'h00;
      regAddr <= 8'h00;
    end else if (doWrite && writeOk && wStrbHeld[0]) begin
      if (awAddrHeld == ssa_pkg::OFF_POINTER) begin
        pointer <= wDataHeld[7:0];
      end
      if (awAddrHeld == ssa_pkg::OFF_REGADDR) begin
        regAddr <= wDataHeld[7:0];
      end
    end
  end

  // A start while busy or halted is dropped; illegal opcodes only raise the sticky bit
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      startPulse <= 1'b0;
      illegal    <= 1'b0;
    end else begin
      startPulse <= doWrite && awAddrHeld == ssa_pkg::OFF_CTRL && wStrbHeld[0]
                    && wDataHeld[ssa_pkg::CTRL_START] && state == IDLE;
      if (startPulse && state == IDLE && !legal) begin
        illegal <= 1'b1;
      end else if (doWrite && awAddrHeld == ssa_pkg::OFF_CTRL && wStrbHeld[0]
                   && wDataHeld[ssa_pkg::CTRL_CLR_ILL]) begin
        illegal <= 1'b0;
      end
    end
  end

  always_comb begin
    readWord = 32'h0000_0000;
    readResp = ssa_pkg::RESP_OKAY;
    unique case (araddr)
      ssa_pkg::OFF_CTRL:    readWord = 32'h0000_0000;
      ssa_pkg::OFF_INSTR:   readWord = {8'h00, instr};
      ssa_pkg::OFF_STATUS: begin
        readWord[ssa_pkg::STAT_BUSY]    = busy;
        readWord[ssa_pkg::STAT_HALTED]  = (state == HALTED);
        readWord[ssa_pkg::STAT_ILLEGAL] = illegal;
      end
      ssa_pkg::OFF_FLAGS:   readWord = {24'h00_0000, flags};
      ssa_pkg::OFF_POINTER: readWord = {24'h00_0000, pointer};
      ssa_pkg::OFF_PC:      readWord = {16'h0000, pc};
      ssa_pkg::OFF_REGADDR: readWord = {24'h00_0000, regAddr};
      ssa_pkg::OFF_REGDATA: begin
        if (editable) begin
          readWord = {24'h00_0000, rfBus.rdataA};
        end else begin
          readResp = ssa_pkg::RESP_SLVERR;
        end
      end
      default: readResp = ssa_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ssa_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= readWord;
      rresp   <= readResp;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Reference values that only the checks below read
  logic       carryUsed;
  logic [7:0] expDiff;
  logic       expBorrow;
  logic       expHalf;
  logic       subExec;
  logic       shiftExec;
  assign carryUsed = (aluOp == ssa_pkg::ALU_SBC) ? flags[ssa_pkg::FLAG_C] : 1'b0;
  assign expDiff   = aluBus.dst - aluBus.src - {7'h00, carryUsed};
  assign expBorrow = {1'b0, aluBus.dst} < ({1'b0, aluBus.src} + {8'h00, carryUsed});
  assign expHalf   = {1'b0, aluBus.dst[3:0]} < ({1'b0, aluBus.src[3:0]} + {4'h0, carryUsed});
  assign subExec   = state == EXECUTE && !isStop && aluOp != ssa_pkg::ALU_SHIFT;
  assign shiftExec = state == EXECUTE && !isStop && aluOp == ssa_pkg::ALU_SHIFT;

  chk_shift_value: assert property (@(posedge mclk) disable iff (!resetn)
    shiftExec |-> rfBus.we && rfBus.wdata == {aluBus.dst[7], aluBus.dst[7:1]})
    else $error("shift result wrong");
  chk_shift_flags: assert property (@(posedge mclk) disable iff (!resetn)
    shiftExec |=> flags[ssa_pkg::FLAG_C] == $past(aluBus.dst[0]) && !flags[ssa_pkg::FLAG_V]
      && flags[ssa_pkg::FLAG_D] == $past(flags[ssa_pkg::FLAG_D]))
    else $error("shift flags wrong");
  chk_work_decode: assert property (@(posedge mclk) disable iff (!resetn)
    (state == RESOLVE && instr[7:0] == ssa_pkg::OP_SHIFT_R && b1[7:4] == ssa_pkg::WORK_NIBBLE)
      |=> dstEff == {pointer[7:4], b1[3:0]})
    else $error("working register decode wrong");
  chk_sub_writeback: assert property (@(posedge mclk) disable iff (!resetn)
    subExec |-> rfBus.we && rfBus.waddr == dstEff && rfBus.wdata == expDiff)
    else $error("subtract write-back wrong");
  chk_sub_borrow: assert property (@(posedge mclk) disable iff (!resetn)
    subExec |=> flags[ssa_pkg::FLAG_C] == $past(expBorrow))
    else $error("borrow flag wrong");
  chk_half_borrow: assert property (@(posedge mclk) disable iff (!resetn)
    subExec |=> flags[ssa_pkg::FLAG_H] == $past(expHalf))
    else $error("half borrow flag wrong");
  chk_decimal_zero: assert property (@(posedge mclk) disable iff (!resetn)
    subExec |=> flags[ssa_pkg::FLAG_D] && flags[ssa_pkg::FLAG_Z] == ($past(expDiff) == 8'h00))
    else $error("decimal or zero flag wrong");
  chk_short_length: assert property (@(posedge mclk) disable iff (!resetn)
    (state == IDLE && startPulse && legal && cycles == ssa_pkg::CYC_SHORT) |=> busy[*6] ##1 !busy)
    else $error("short instruction length wrong");
  chk_long_length: assert property (@(posedge mclk) disable iff (!resetn)
    (state == IDLE && startPulse && legal && cycles == ssa_pkg::CYC_LONG)
      |=> busy[*8] ##1 busy[*2] ##1 !busy)
    else $error("long instruction length wrong");
  chk_halt_held: assert property (@(posedge mclk) disable iff (!resetn)
    state == HALTED |=> state == HALTED && !sclkEnable && !xtalEnable && pc == $past(pc))
    else $error("halted state left without reset");
  chk_stop_entry: assert property (@(posedge mclk) disable iff (!resetn)
    (state == IDLE && startPulse && isStop) |-> ##7 state == HALTED && !sclkEnable
      && flags == $past(flags, 7))
    else $error("stop entry wrong");

endmodule // shift_subtract_stop_alu

`default_nettype wire

// file: shift_subtract_stop_alu_test.sv
/* Self-checking bench for shift_subtract_stop_alu: reset and bus error cases, then
   a table of instructions, then illegal opcode, halt and restart cases. Assumes the AXI4-Lite map of ssa_pkg. */
`timescale 1ns/10ps
`default_nettype none
module shift_subtract_stop_alu_test;
  typedef struct packed {
    logic [23:0] ins;
    logic [7:0]  sa, sv, da, dv, fin, res, fout;
  } row_t;
  logic        mclk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sclkEnable, xtalEnable;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  int          n_errors, comparisons, cycles;
  row_t        r;
  // Order: opcode word, source addr/value, dest addr/value, flags in, result, flags out
  row_t rows [14] = '{
    80'h341224_12_1b_34_2e_00_13_08,
    80'h341234_12_1b_34_2e_80_12_08,
    80'h003b22_4b_20_43_16_00_f6_a8,
    80'h003b32_4b_20_43_16_80_f5_a8,
    80'h036c26_ff_00_6c_2a_00_27_08,
    80'h036c36_ff_00_6c_2a_80_26_08,
    80'h02d427_d4_5f_5f_4c_00_4a_08,
    80'h02d437_d4_5f_5f_4c_80_49_08,
    80'h00e6d0_ff_00_46_31_0c_18_8c,
    80'h00c6d1_c6_df_df_b8_10_dc_20,
    80'h800124_01_01_80_80_00_7f_1c,
    80'h030224_02_55_03_55_00_00_48,
    80'h00fa23_4a_20_4f_16_00_05_08,
    80'h4be335_43_10_4b_82_80_80_28
  };

  shift_subtract_stop_alu dut (.mclk, .resetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .sclkEnable, .xtalEnable);

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    got = rdata;
    resp = rresp;
  endtask

  task automatic poke(input logic [7:0] a, input logic [7:0] v);
    wr(ssa_pkg::OFF_REGADDR, {24'h0, a});
    wr(ssa_pkg::OFF_REGDATA, {24'h0, v});
  endtask

  task automatic peek(input logic [7:0] a);
    wr(ssa_pkg::OFF_REGADDR, {24'h0, a});
    rd(ssa_pkg::OFF_REGDATA);
  endtask

  // Busy rises at the edge that ends the start write; the wait is only slack
  task automatic exec(input logic [23:0] ins);
    wr(ssa_pkg::OFF_INSTR, {8'h0, ins});
    wr(ssa_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
    do rd(ssa_pkg::OFF_STATUS); while (got[ssa_pkg::STAT_BUSY] !== 1'h0);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    @(posedge mclk);
    rd(ssa_pkg::OFF_PC);
    chk("pc", 32'h0c, got);
    wr(8'h40, 32'h0);
    chk("bresp", 32'h2, {30'h0, resp});
    rd(8'h44);
    chk("rresp", 32'h2, {30'h0, resp});
    $display("bus error cases done");
    wr(ssa_pkg::OFF_POINTER, 32'h40);
    poke(8'h20, 8'h11);
    poke(8'h10, 8'h01);
    foreach (rows[i]) begin
      r = rows[i];
      wr(ssa_pkg::OFF_FLAGS, {24'h0, r.fin});
      poke(r.sa, r.sv);
      poke(r.da, r.dv);
      exec(r.ins);
      peek(r.da);
      chk("result", {24'h0, r.res}, got);
      rd(ssa_pkg::OFF_FLAGS);
      chk("flags", {24'h0, r.fout}, got);
      peek(r.sa);
      chk("source", {24'h0, r.sv}, got);
      $display("row %0d done", i);
    end
    // An undecoded code only raises the sticky bit, which CTRL bit 1 clears
    wr(ssa_pkg::OFF_INSTR, 32'h28);
    wr(ssa_pkg::OFF_CTRL, 32'h1);
    rd(ssa_pkg::OFF_STATUS);
    chk("status", 32'h4, got);
    wr(ssa_pkg::OFF_CTRL, 32'h2);
    rd(ssa_pkg::OFF_STATUS);
    chk("status", 32'h0, got);
    $display("illegal opcode done");
    wr(ssa_pkg::OFF_FLAGS, 32'ha8);
    exec(24'h00006f);
    chk("sclk", 32'h0, {31'h0, sclkEnable});
    chk("crystal_oscillator", 32'h0, {31'h0, xtalEnable});
    rd(ssa_pkg::OFF_STATUS);
    chk("status", 32'h2, got);
    rd(ssa_pkg::OFF_PC);
    chk("pc", 32'h31, got);
    // A later start must not run while halted
    wr(ssa_pkg::OFF_INSTR, 32'h341224);
    wr(ssa_pkg::OFF_CTRL, 32'h1);
    repeat (14) @(posedge mclk);
    rd(ssa_pkg::OFF_FLAGS);
    chk("flags", 32'ha8, got);
    chk("sclk", 32'h0, {31'h0, sclkEnable});
    resetn <= 1'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    @(posedge mclk);
    chk("sclk", 32'h1, {31'h0, sclkEnable});
    chk("crystal_oscillator", 32'h1, {31'h0, xtalEnable});
    rd(ssa_pkg::OFF_PC);
    chk("pc", 32'h0c, got);
    $display("halt and restart done");
    report_and_stop();
  end
endmodule // shift_subtract_stop_alu_test
`default_nettype wire
